// ### shared/comparator_pkg.sv
// constants and types for the analog comparator control block
package comparator_pkg;

  // register indices on the plain register port
  localparam logic [1:0] CONV_CTRL_B_ADDR   = 2'h0;
  localparam logic [1:0] CTRL_STATUS_ADDR   = 2'h1;
  localparam logic [1:0] PIN_DISABLE_ADDR   = 2'h2;
  localparam logic [1:0] CONV_CTRL_A_ADDR   = 2'h3;

  // control and status field positions
  localparam int CS_OFF_BIT     = 7;
  localparam int CS_BANDGAP_BIT = 6;
  localparam int CS_RESULT_BIT  = 5;
  localparam int CS_FLAG_BIT    = 4;
  localparam int CS_IRQ_EN_BIT  = 3;
  localparam int CS_CAPTURE_BIT = 2;
  localparam int CS_MODE_HI_BIT = 1;
  localparam int CS_MODE_LO_BIT = 0;

  // converter control b: multiplexer enable
  localparam int CB_MUX_EN_BIT  = 6;
  // converter control a: converter on
  localparam int CA_CONV_ON_BIT = 7;

  // pin input disable fields
  localparam int PD_NEG_BIT     = 1;
  localparam int PD_POS_BIT     = 0;

  // reset values
  localparam logic [7:0] CONV_CTRL_B_RESET = 8'h00;
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [7:0] PIN_DISABLE_RESET = 8'h00;
  localparam logic [7:0] CONV_CTRL_A_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_TOGGLE   = 2'h0,
    MODE_RESERVED = 2'h1,
    MODE_FALLING  = 2'h2,
    MODE_RISING   = 2'h3
  } event_mode_t;

endpackage

// ### src/comparator_sync.sv
// two-flop synchroniser for the comparator output
`timescale 1ns/1ps
module comparator_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // asynchronous level in, synchronised level out
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_reg;
  logic sync_reg;

  // meta_reg is read only by sync_reg
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule

// ### src/analog_comparator_control.sv
// analog comparator control, event detection and register file
// Function
// (R1) raw result high when selected positive input exceeds selected negative input
// (R2) mux enabled and converter off: channel select picks converter input 0..7
// (R3) mux disabled or converter on: negative pin feeds negative input
// (R4) bandgap select chooses bandgap, else positive pin, for positive input
// (R5) result bit is synchronised, one to two cycles late
// (R6) comparator-off bit powers comparator down, zero powers it up
// (R7) event flag set on the edge chosen by event mode
// (R8) flag cleared by interrupt acknowledge or by writing one
// (R9) interrupt request when flag, irq enable and global enable all set
// (R10) capture route on: comparator output feeds timer capture front end
// (R11) capture route off: timer capture sees nothing from comparator
// (R12) mode 00 toggle, 01 reserved, 10 falling, 11 rising
// (R13) software disables irq before changing event mode
// (R14) software disables irq before toggling comparator-off
// (R15) control/status bit layout fixed from off at 7 to mode at 1:0
// (R16) digital-off bit kills pin input buffer, port bit reads zero
// (R17) pin disable register bits 7..2 read zero
// (R18) software clears converter power gate before using the mux
// (R19) software also sets timer capture irq enable for capture interrupts
// (R20) edges found by comparing synchronised output with its previous value
`timescale 1ns/1ps
module analog_comparator_control
  import comparator_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // register port
  input  wire logic [1:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_write_i,
  input  wire logic       reg_read_i,
  output logic      [7:0] reg_rdata_o,
  // analog front end: comparison outcomes per selected pair (digital model)
  input  wire logic [7:0] pos_gt_conv_i,
  input  wire logic [7:0] bg_gt_conv_i,
  input  wire logic       pos_gt_neg_i,
  input  wire logic       bg_gt_neg_i,
  output logic            comparator_power_o,
  output logic            bandgap_select_o,
  output logic            neg_use_mux_o,
  output logic      [2:0] channel_select_o,
  // converter multiplexer channel select
  input  wire logic [2:0] channel_select_i,
  // cpu interrupt
  input  wire logic       global_irq_enable_i,
  input  wire logic       irq_ack_i,
  output logic            irq_o,
  // timer capture
  output logic            capture_o,
  // pin digital input buffers
  input  wire logic       positive_input_pin_i,
  input  wire logic       negative_input_pin_i,
  output logic            positive_pin_digital_o,
  output logic            negative_pin_digital_o,
  output logic            positive_pin_buffer_en_o,
  output logic            negative_pin_buffer_en_o
);

  // ==========================================================
  // registers
  logic [7:0] conv_ctrl_b_reg;
  logic [7:0] conv_ctrl_a_reg;
  logic       comparator_off_reg;
  logic       bandgap_select_reg;
  logic       compare_event_flag_reg;
  logic       compare_irq_enable_reg;
  logic       capture_route_enable_reg;
  logic [1:0] event_mode_reg;
  logic [1:0] pin_disable_reg;
  logic [7:0] rdata_reg;
  logic       result_prev_reg;
  logic       pos_pin_meta_reg;
  logic       pos_pin_reg;
  logic       neg_pin_meta_reg;
  logic       neg_pin_reg;

  function automatic logic sel_hit(input logic [1:0] a, input logic [1:0] target);
    sel_hit = (a == target);
  endfunction

  // ==========================================================
  // input selection and raw comparison
  logic negative_mux_enable;
  logic converter_on;
  logic use_mux;
  logic raw_result;
  logic gated_result;
  logic compare_result;

  assign negative_mux_enable = conv_ctrl_b_reg[CB_MUX_EN_BIT];
  assign converter_on        = conv_ctrl_a_reg[CA_CONV_ON_BIT];
  assign use_mux             = negative_mux_enable && !converter_on;  // see R2 see R3
  assign neg_use_mux_o       = use_mux;
  assign channel_select_o    = channel_select_i;
  assign bandgap_select_o    = bandgap_select_reg;                    // see R4
  assign comparator_power_o  = !comparator_off_reg;                   // see R6

  // positive and negative choices together pick one precomputed comparison
  assign raw_result = use_mux ?
                      (bandgap_select_reg ? bg_gt_conv_i[channel_select_i]
                                          : pos_gt_conv_i[channel_select_i])
                    : (bandgap_select_reg ? bg_gt_neg_i : pos_gt_neg_i); // see R1 see R4
  // a powered-down comparator reads low; no drift on the output
  assign gated_result = raw_result && !comparator_off_reg;

  comparator_sync u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (gated_result),
    .sync_o  (compare_result)   // see R5
  );

  // ==========================================================
  // edge detection and event flag
  logic rise_edge;
  logic fall_edge;
  logic event_hit;
  logic write_ctrl;
  logic flag_clear;
  logic flag_next;

  assign rise_edge = compare_result && !result_prev_reg;   // see R20
  assign fall_edge = !compare_result && result_prev_reg;   // see R20
  assign event_hit = (sel_hit(event_mode_reg, MODE_TOGGLE) && (rise_edge || fall_edge))
                   || (sel_hit(event_mode_reg, MODE_FALLING) && fall_edge)
                   || (sel_hit(event_mode_reg, MODE_RISING) && rise_edge); // see R7 see R12
  assign write_ctrl = reg_write_i && (reg_addr_i == CTRL_STATUS_ADDR);
  assign flag_clear = irq_ack_i || (write_ctrl && reg_wdata_i[CS_FLAG_BIT]); // see R8
  // a new event beats a clear in the same cycle
  assign flag_next  = event_hit || (compare_event_flag_reg && !flag_clear);

  assign irq_o = compare_event_flag_reg && compare_irq_enable_reg
               && global_irq_enable_i;                                // see R9
  assign capture_o = capture_route_enable_reg && compare_result;      // see R10 see R11

  // ==========================================================
  // pin digital input buffers
  assign positive_pin_buffer_en_o = !pin_disable_reg[PD_POS_BIT];
  assign negative_pin_buffer_en_o = !pin_disable_reg[PD_NEG_BIT];
  assign positive_pin_digital_o   = pos_pin_reg && !pin_disable_reg[PD_POS_BIT]; // see R16
  assign negative_pin_digital_o   = neg_pin_reg && !pin_disable_reg[PD_NEG_BIT]; // see R16

  // ==========================================================
  // register read
  logic [7:0] ctrl_status_view;
  logic [7:0] read_mux;

  assign ctrl_status_view = {comparator_off_reg, bandgap_select_reg, compare_result,
                             compare_event_flag_reg, compare_irq_enable_reg,
                             capture_route_enable_reg, event_mode_reg}; // see R15
  assign read_mux = (reg_addr_i == CONV_CTRL_B_ADDR) ? conv_ctrl_b_reg
                  : (reg_addr_i == CTRL_STATUS_ADDR) ? ctrl_status_view
                  : (reg_addr_i == PIN_DISABLE_ADDR) ? {6'h00, pin_disable_reg} // see R17
                  : conv_ctrl_a_reg;
  assign reg_rdata_o = rdata_reg;

  // ==========================================================
  // sequential logic
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
    end else if (reg_read_i) begin
      rdata_reg <= read_mux;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pos_pin_meta_reg <= 1'b0;
      pos_pin_reg      <= 1'b0;
      neg_pin_meta_reg <= 1'b0;
      neg_pin_reg      <= 1'b0;
      result_prev_reg  <= 1'b0;
    end else begin
      pos_pin_meta_reg <= positive_input_pin_i;
      pos_pin_reg      <= pos_pin_meta_reg;
      neg_pin_meta_reg <= negative_input_pin_i;
      neg_pin_reg      <= neg_pin_meta_reg;
      result_prev_reg  <= compare_result;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      conv_ctrl_b_reg          <= CONV_CTRL_B_RESET;
      conv_ctrl_a_reg          <= CONV_CTRL_A_RESET;
      comparator_off_reg       <= CTRL_STATUS_RESET[CS_OFF_BIT];
      bandgap_select_reg       <= CTRL_STATUS_RESET[CS_BANDGAP_BIT];
      compare_irq_enable_reg   <= CTRL_STATUS_RESET[CS_IRQ_EN_BIT];
      capture_route_enable_reg <= CTRL_STATUS_RESET[CS_CAPTURE_BIT];
      event_mode_reg           <= CTRL_STATUS_RESET[CS_MODE_HI_BIT:CS_MODE_LO_BIT];
      pin_disable_reg          <= PIN_DISABLE_RESET[PD_NEG_BIT:PD_POS_BIT];
      compare_event_flag_reg   <= CTRL_STATUS_RESET[CS_FLAG_BIT];
    end else begin
      compare_event_flag_reg <= flag_next;
      if (reg_write_i && (reg_addr_i == CONV_CTRL_B_ADDR)) begin
        conv_ctrl_b_reg <= reg_wdata_i;
      end
      if (reg_write_i && (reg_addr_i == CONV_CTRL_A_ADDR)) begin
        conv_ctrl_a_reg <= reg_wdata_i;
      end
      if (reg_write_i && (reg_addr_i == PIN_DISABLE_ADDR)) begin
        pin_disable_reg <= reg_wdata_i[PD_NEG_BIT:PD_POS_BIT];
      end
      if (write_ctrl) begin
        comparator_off_reg       <= reg_wdata_i[CS_OFF_BIT];     // see R6
        bandgap_select_reg       <= reg_wdata_i[CS_BANDGAP_BIT];
        compare_irq_enable_reg   <= reg_wdata_i[CS_IRQ_EN_BIT];
        capture_route_enable_reg <= reg_wdata_i[CS_CAPTURE_BIT];
        event_mode_reg           <= reg_wdata_i[CS_MODE_HI_BIT:CS_MODE_LO_BIT];
      end
    end
  end

  // ==========================================================
  // assertions
  sequence rise_seen_s;
    compare_result && !result_prev_reg;
  endsequence

  irq_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R9
    irq_o == (compare_event_flag_reg && compare_irq_enable_reg && global_irq_enable_i))
    else $error("irq does not follow flag and enables");

  rising_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R7
    (rise_seen_s and sel_hit(event_mode_reg, MODE_RISING)) |=> compare_event_flag_reg)
    else $error("rising edge did not set flag");

  reserved_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R12
    (sel_hit(event_mode_reg, MODE_RESERVED) && !compare_event_flag_reg && !irq_ack_i)
    |=> !compare_event_flag_reg)
    else $error("reserved mode set the flag");

  flag_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R8
    (irq_ack_i && !event_hit) |=> !compare_event_flag_reg)
    else $error("acknowledge did not clear flag");

  sync_delay_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R5
    $rose(gated_result) ##1 gated_result |=> compare_result)
    else $error("result not synchronised in two cycles");

  capture_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R11
    !capture_route_enable_reg |-> !capture_o)
    else $error("capture driven while route disabled");

  pin_disable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R16
    pin_disable_reg[PD_POS_BIT] |-> !positive_pin_digital_o && !positive_pin_buffer_en_o)
    else $error("disabled pin still reads");

  read_reserved_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R17
    (reg_read_i && reg_addr_i == PIN_DISABLE_ADDR) |=> reg_rdata_o[7:2] == 6'h00)
    else $error("reserved pin disable bits not zero");

  mux_select_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R3
    converter_on |-> !neg_use_mux_o)
    else $error("mux used while converter on");

  off_power_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R6
    (write_ctrl && reg_wdata_i[CS_OFF_BIT]) |=> !comparator_power_o)
    else $error("comparator still powered after off write");

  // the toggle and latency checks lean on sampled history, not on the edge terms above
  sequence fall_seen_s;
    !compare_result && result_prev_reg;
  endsequence

  sequence event_armed_s;
    event_hit && compare_irq_enable_reg && !write_ctrl;
  endsequence

  falling_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R7
    (fall_seen_s and sel_hit(event_mode_reg, MODE_FALLING)) |=> compare_event_flag_reg)
    else $error("falling edge did not set flag");

  toggle_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R12
    (sel_hit(event_mode_reg, MODE_TOGGLE) && $changed(compare_result))
    |=> compare_event_flag_reg)
    else $error("toggle did not set flag");

  irq_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R9
    event_armed_s ##1 global_irq_enable_i |-> irq_o)
    else $error("armed event raised no interrupt request");

  write_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R8
    (write_ctrl && reg_wdata_i[CS_FLAG_BIT] && !event_hit) |=> !compare_event_flag_reg)
    else $error("write of one did not clear flag");

  capture_on_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R10
    (capture_route_enable_reg && compare_result) |-> capture_o)
    else $error("capture not fed while route enabled");

  sync_late_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R5
    $rose(compare_result) |-> $past(gated_result, 2))
    else $error("result rose without a synchronised cause");

  neg_pin_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R16
    pin_disable_reg[PD_NEG_BIT] |-> !negative_pin_digital_o && !negative_pin_buffer_en_o)
    else $error("disabled negative pin still reads");

endmodule

// ### verification/analog_front_model.sv
// behavioural model of the analog nodes feeding the comparator block
`timescale 1ns/1ps
module analog_front_model (
  // node voltages set by the bench
  input  wire logic [7:0]  v_pos_i,
  input  wire logic [7:0]  v_neg_i,
  input  wire logic [7:0]  v_bg_i,
  input  wire logic [63:0] v_conv_i,
  // comparison levels and pin levels towards the block
  output logic      [7:0]  pos_gt_conv_o,
  output logic      [7:0]  bg_gt_conv_o,
  output logic             pos_gt_neg_o,
  output logic             bg_gt_neg_o,
  output logic             pos_pin_o,
  output logic             neg_pin_o
);
  // ==========================================================
  // comparisons
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      pos_gt_conv_o[k] = v_pos_i > v_conv_i[8*k +: 8];
      bg_gt_conv_o[k]  = v_bg_i > v_conv_i[8*k +: 8];
    end
  end
  assign pos_gt_neg_o = v_pos_i > v_neg_i;
  assign bg_gt_neg_o  = v_bg_i > v_neg_i;
  // ==========================================================
  // pin levels: mid-rail threshold, no hysteresis modelled
  assign pos_pin_o = v_pos_i[7];
  assign neg_pin_o = v_neg_i[7];
endmodule

// ### verification/analog_comparator_control_bench.sv
// self-checking bench for the analog comparator control block
`timescale 1ns/1ps
module analog_comparator_control_bench;
  import comparator_pkg::*;
  logic clk_i, rst_n_i, wr_i, rd_i, glb, ack, irq, cap, pwr, bgo, nmux, ppin, npin;
  logic pdig, ndig, pbuf, nbuf, pgn, bgn, bg, mux, con;
  logic [1:0] addr;
  logic [7:0] wd, rdat, pgc, bgc, vp, vn, vb, d;
  logic [63:0] vc;
  logic [2:0] ch, chi, cho;
  int failures, checks, cycles;
  analog_front_model afe (.v_pos_i(vp), .v_neg_i(vn), .v_bg_i(vb), .v_conv_i(vc),
    .pos_gt_conv_o(pgc), .bg_gt_conv_o(bgc), .pos_gt_neg_o(pgn), .bg_gt_neg_o(bgn),
    .pos_pin_o(ppin), .neg_pin_o(npin));
  analog_comparator_control uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_write_i(wr_i), .reg_read_i(rd_i), .reg_rdata_o(rdat),
    .pos_gt_conv_i(pgc), .bg_gt_conv_i(bgc), .pos_gt_neg_i(pgn), .bg_gt_neg_i(bgn),
    .comparator_power_o(pwr), .bandgap_select_o(bgo), .neg_use_mux_o(nmux),
    .channel_select_o(cho), .channel_select_i(chi), .global_irq_enable_i(glb),
    .irq_ack_i(ack), .irq_o(irq), .capture_o(cap), .positive_input_pin_i(ppin),
    .negative_input_pin_i(npin), .positive_pin_digital_o(pdig),
    .negative_pin_digital_o(ndig), .positive_pin_buffer_en_o(pbuf),
    .negative_pin_buffer_en_o(nbuf));
  // ==========================================================
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  // ==========================================================
  // tasks
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr <= a;
    wd   <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdat;
  endtask
  task automatic ack_pulse();
    @(posedge clk_i);
    ack <= 1'b1;
    @(posedge clk_i);
    ack <= 1'b0;
  endtask
  function automatic logic exp_res();
    logic [7:0] p;
    logic [7:0] n;
    p = bg ? vb : vp;
    n = (mux && !con) ? vc[8*ch +: 8] : vn;
    return p > n;
  endfunction
  // ==========================================================
  // main sequence
  initial begin
    {wr_i, rd_i, glb, ack, bg, mux, con} = '0;
    addr = 2'h0;
    wd = 8'h00;
    ch = 3'h0;
    chi = 3'h0;
    {failures, checks, cycles} = '0;
    vp = 8'h32;
    vn = 8'h64;
    vb = 8'h14;
    for (int k = 0; k < 8; k++) vc[8*k +: 8] = 8'(k * 32);
    rst_n_i = 1'b0;
    wait_n(5);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(2'(a), d);
      chk8(d, 8'h00);
    end
    chk1(pwr, 1'b1);
    chk1(pbuf, 1'b1);
    // event modes, interrupt kept off while mode changes
    for (int m = 0; m < 4; m++) begin
      wr(CTRL_STATUS_ADDR, 8'(m));
      wait_n(4);
      wr(CTRL_STATUS_ADDR, 8'(8'h10 | m));
      vp <= 8'h96;
      wait_n(5);
      rd(CTRL_STATUS_ADDR, d);
      chk1(d[CS_FLAG_BIT], m == 0 || m == 3);
      chk1(d[CS_RESULT_BIT], 1'b1);
      wr(CTRL_STATUS_ADDR, 8'(8'h10 | m));
      vp <= 8'h32;
      wait_n(5);
      rd(CTRL_STATUS_ADDR, d);
      chk1(d[CS_FLAG_BIT], m == 0 || m == 2);
    end
    // interrupt request gating and vector clear
    wr(CTRL_STATUS_ADDR, 8'h1B);
    glb <= 1'b1;
    vp <= 8'h96;
    wait_n(5);
    chk1(irq, 1'b1);
    glb <= 1'b0;
    wait_n(1);
    chk1(irq, 1'b0);
    glb <= 1'b1;
    ack_pulse();
    wait_n(1);
    chk1(irq, 1'b0);
    wr(CTRL_STATUS_ADDR, 8'h03);
    // negative input selection across all channels
    vp <= 8'h64;
    vn <= 8'hC8;
    mux = 1'b1;
    // converter power gate has no model here; taken as already cleared
    wr(CONV_CTRL_B_ADDR, 8'h40);
    for (int k = 0; k < 8; k++) begin
      ch = 3'(k);
      chi <= 3'(k);
      wait_n(4);
      rd(CTRL_STATUS_ADDR, d);
      chk1(d[CS_RESULT_BIT], exp_res());
      chk1(nmux, 1'b1);
      chk8({5'h00, cho}, {5'h00, ch});
    end
    ch = 3'h1;
    chi <= 3'h1;
    con = 1'b1;
    wr(CONV_CTRL_A_ADDR, 8'h80);
    wait_n(4);
    rd(CTRL_STATUS_ADDR, d);
    chk1(d[CS_RESULT_BIT], exp_res());
    chk1(nmux, 1'b0);
    con = 1'b0;
    wr(CONV_CTRL_A_ADDR, 8'h00);
    bg = 1'b1;
    wr(CTRL_STATUS_ADDR, 8'h43);
    wait_n(4);
    rd(CTRL_STATUS_ADDR, d);
    chk8(d & 8'hEF, {2'h1, exp_res(), 5'h03});
    chk1(bgo, 1'b1);
    // capture routing
    bg = 1'b0;
    wr(CTRL_STATUS_ADDR, 8'h07);
    wait_n(4);
    // timer side is not modelled; its capture interrupt enable is taken as set
    chk1(cap, exp_res());
    wr(CTRL_STATUS_ADDR, 8'h03);
    wait_n(2);
    chk1(cap, 1'b0);
    // power down: output forced low
    wr(CTRL_STATUS_ADDR, 8'h83);
    wait_n(4);
    chk1(pwr, 1'b0);
    rd(CTRL_STATUS_ADDR, d);
    chk8(d & 8'hE0, 8'h80);
    wr(CTRL_STATUS_ADDR, 8'h03);
    wait_n(1);
    chk1(pwr, 1'b1);
    // pin digital input disable
    vp <= 8'hC8;
    wr(PIN_DISABLE_ADDR, 8'hFF);
    rd(PIN_DISABLE_ADDR, d);
    chk8(d, 8'h03);
    wait_n(3);
    chk1(pbuf, 1'b0);
    chk1(nbuf, 1'b0);
    chk1(pdig, 1'b0);
    chk1(ndig, 1'b0);
    wr(PIN_DISABLE_ADDR, 8'h00);
    wait_n(4);
    chk1(pdig, 1'b1);
    chk1(ndig, 1'b1);
    chk1(pbuf, 1'b1);
    chk1(nbuf, 1'b1);
    print_verdict();
  end
endmodule
